// *** lsc_defs.svh ***
// Purpose: named constants for the list sequencer command checker
// Assumes: byte addresses on an APB bus with 32-bit data
// Notes:   error codes are held as magnitudes; the host reads them as negative
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH
// =====================================================
// register byte offsets
`define LSC_REG_CMD      8'h00
`define LSC_REG_ARG0     8'h04
`define LSC_REG_ARG1     8'h08
`define LSC_REG_ARRAY    8'h0C
`define LSC_REG_STATUS   8'h10
`define LSC_REG_ERRQ     8'h14
`define LSC_REG_POINTS   8'h18
`define LSC_REG_QSTART   8'h1C
`define LSC_REG_RES0     8'h20
`define LSC_REG_RES1     8'h24
`define LSC_REG_RES2     8'h28
`define LSC_REG_SAMPINFO 8'h2C
`define LSC_REG_SAMPDUR  8'h30
`define LSC_REG_TRIGCFG  8'h34
`define LSC_REG_SAMP0    8'h40
`define LSC_SAMP_SHIFT   2
// =====================================================
// error codes
`define LSC_ERR_NONE     9'h000
`define LSC_ERR_COMMAND  9'h064
`define LSC_ERR_CONFLICT 9'h0DD
`define LSC_ERR_RANGE    9'h0DE
`define LSC_ERR_TOOMUCH  9'h0DF
`define LSC_ERR_LENGTH   9'h0E2
// =====================================================
// limits, times in microseconds
`define LSC_DWELL_MIN_US 16'h005D
`define LSC_DWELL_MAX_US 16'h84D0
`define LSC_PULSE_MIN_US 16'h00FA
`define LSC_PULSE_MAX_US 16'h84D0
`define LSC_PTS_MINRES   13'h0F5D
`define LSC_PTS_MAXRES   13'h170C
`define LSC_SAMP_MAX     4'h8
`define LSC_AVG_MIN      9'h002
`define LSC_AVG_MAX      9'h100
`define LSC_CHAR_V       8'h56
`define LSC_CHAR_C       8'h43
`endif

// *** lsc_pkg.sv ***
// Purpose: types shared by the list sequencer command checker
// Assumes: lsc_defs.svh holds the numbers
// Notes:   opcodes are the values written to the command register
package lsc_pkg;
   // =====================================================
   // commands
   typedef enum logic [3:0] {
      OP_NONE       = 4'h0,
      OP_SET_VOLT   = 4'h1,
      OP_SET_CURR   = 4'h2,
      OP_DWELL      = 4'h3,
      OP_COPY       = 4'h4,
      OP_SAMP_CURR  = 4'h5,
      OP_SAMP_VOLT  = 4'h6,
      OP_SAMP_DUR   = 4'h7,
      OP_TRIG_SET   = 4'h8,
      OP_CLEAR      = 4'h9,
      OP_QSTART_SET = 4'hA
   } lsc_op_t;
   // =====================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_COPY = 3'b010,
      ST_FILL = 3'b100
   } lsc_state_t;
   // =====================================================
   // list pointers
   typedef struct packed {
      logic [12:0] setCnt;
      logic [12:0] dwellCnt;
   } lsc_ptrs_t;
endpackage : lsc_pkg

// *** lsc_command_checker.sv ***
// Purpose: checks and executes list programming commands from an APB host
// Assumes: one command in flight; host polls status and error queue
// Notes:   setpoints are signed 16-bit, dwell and pulse times in microseconds
// What this block does
// - return the readback start location on query
// - copy dwell range to list end, setpoints from supplied array in turn
// - stop copying on invalid setpoint, array used up, or list full
// - copy without prior setpoint entry or bad range gives settings conflict
// - copy with dwell and setpoint counts differing gives length mismatch
// - resolution query returns dwell bounds and 3933 or 5900 points
// - refuse dwell below 93 us or above 34 ms
// - averaging is power of two 2..256, others rounded down, values below 2 raised to 2
// - sampling adds averaging-count points to the list
// - sampling without sample duration set gives settings conflict
// - sampling must follow setpoint entry or duration setting, else conflict
// - sampling with dwell and setpoint counts differing gives length mismatch
// - ninth sampling command in one list gives too-much-data
// - total points above 3933 with samples gives too-much-data
// - sample query returns sample point indices and V or C type
// - sample duration 250 us..34 ms, settable once, again is command error
// - duration query returns value, or command error when unset
// - trigger width set makes output-off flag follow trigger pulse until clear
// - trigger polarity ON conducts during pulse, OFF does not
// - list clear resets every pointer to zero
// - errors posted to a queue as numeric code for the host
//
// Our own choices: the register offsets and register access over APB.
`include "lsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lsc_command_checker
   import lsc_pkg::*;
#(
   parameter int                 DEPTH     = 5900,
   parameter int                 ARR_DEPTH = 16,
   parameter int                 EQ_DEPTH  = 4,
   parameter logic signed [15:0] SET_LIMIT = 16'h1388
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        resMax,
   input  wire logic        trigPulseActive,
   input  wire logic        outputOffState,
   output var  logic        extFlagConduct
);
   // =====================================================
   // state
   logic signed [15:0] setMem   [DEPTH];
   logic        [15:0] dwellMem [DEPTH];
   logic signed [15:0] arrMem   [ARR_DEPTH];
   logic        [12:0] sampIdx  [8];
   logic        [8:0]  eqMem    [EQ_DEPTH];
   lsc_state_t         state;
   lsc_ptrs_t          ptrs;
   lsc_op_t            lastOp;
   logic        [4:0]  arrCnt;
   logic        [4:0]  arrIdx;
   logic        [12:0] cpSrc;
   logic        [12:0] cpStart;
   logic        [12:0] cpEnd;
   logic        [8:0]  fillLeft;
   logic signed [15:0] fillVal;
   logic        [3:0]  sampCnt;
   logic               listCurr;
   logic               sampCurr;
   logic        [15:0] arg0;
   logic        [15:0] arg1;
   logic        [12:0] qStart;
   logic               durSet;
   logic        [15:0] sampDur;
   logic               trigMode;
   logic               trigPolOn;
   logic        [15:0] trigWidth;
   logic        [2:0]  eqWr;
   logic        [2:0]  eqRd;
   logic        [2:0]  eqCnt;
   // =====================================================
   // helpers
   function automatic logic validSet(input logic signed [15:0] v);
      validSet = (v <= SET_LIMIT) && (v >= -SET_LIMIT);
   endfunction : validSet

   function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
      inRange = (v >= lo) && (v <= hi);
   endfunction : inRange

   // round down to a power of two, clamped to 2..256
   function automatic logic [8:0] floorPow2(input logic [15:0] v);
      floorPow2 = `LSC_AVG_MIN;
      for (int i = 2; i <= 8; i++) begin
         if (v >= (16'h0001 << i)) begin
            floorPow2 = 9'(16'h0001 << i);
         end
      end
   endfunction : floorPow2

   // =====================================================
   // bus decode
   logic        busy;
   logic        acc;
   logic        wrAcc;
   logic        rdAcc;
   logic        mapped;
   logic        wrCmd;
   lsc_op_t     op;
   logic [12:0] cap;
   logic [8:0]  avg;
   logic [8:0]  cmdErr;
   logic        ok;

   assign busy    = (state != ST_IDLE);
   assign pready  = !(busy && psel && pwrite);
   assign acc     = psel && penable && pready;
   assign wrAcc   = acc && pwrite;
   assign rdAcc   = acc && !pwrite;
   assign mapped  = (paddr[1:0] == 2'h0) &&
                    ((paddr <= `LSC_REG_TRIGCFG) || (paddr[7:5] == 3'h2));
   assign pslverr = psel && penable && !mapped;
   assign wrCmd   = wrAcc && (paddr == `LSC_REG_CMD);
   assign op      = lsc_op_t'(pwdata[3:0]);
   assign cap     = resMax ? `LSC_PTS_MAXRES : `LSC_PTS_MINRES;
   assign avg     = floorPow2(arg0);
   assign ok      = (cmdErr == `LSC_ERR_NONE);

   // =====================================================
   // precondition checks
   always_comb begin
      cmdErr = `LSC_ERR_NONE;
      case (op)
         OP_SET_VOLT, OP_SET_CURR: begin
            if (ptrs.setCnt != 13'h0 && listCurr != (op == OP_SET_CURR))
               cmdErr = `LSC_ERR_CONFLICT;
            else if (ptrs.setCnt >= cap)
               cmdErr = `LSC_ERR_TOOMUCH;
         end
         OP_DWELL: begin
            if (!inRange(arg0, `LSC_DWELL_MIN_US, `LSC_DWELL_MAX_US))
               cmdErr = `LSC_ERR_RANGE;
            else if (ptrs.dwellCnt >= cap)
               cmdErr = `LSC_ERR_TOOMUCH;
         end
         OP_COPY: begin
            if (!(lastOp == OP_SET_VOLT || lastOp == OP_SET_CURR) ||
                arg0 > arg1 || arg1 >= 16'(ptrs.dwellCnt))
               cmdErr = `LSC_ERR_CONFLICT;
            else if (ptrs.dwellCnt != ptrs.setCnt)
               cmdErr = `LSC_ERR_LENGTH;
         end
         OP_SAMP_CURR, OP_SAMP_VOLT: begin
            if (!durSet)
               cmdErr = `LSC_ERR_CONFLICT;
            else if (!(lastOp == OP_SET_VOLT || lastOp == OP_SET_CURR ||
                       lastOp == OP_SAMP_DUR))
               cmdErr = `LSC_ERR_CONFLICT;
            else if (ptrs.dwellCnt != ptrs.setCnt)
               cmdErr = `LSC_ERR_LENGTH;
            else if (sampCnt == `LSC_SAMP_MAX)
               cmdErr = `LSC_ERR_TOOMUCH;
            else if (14'(ptrs.setCnt) + 14'(avg) > 14'(`LSC_PTS_MINRES))
               cmdErr = `LSC_ERR_TOOMUCH;
         end
         OP_SAMP_DUR: begin
            if (durSet)
               cmdErr = `LSC_ERR_COMMAND;
            else if (!inRange(arg0, `LSC_PULSE_MIN_US, `LSC_PULSE_MAX_US))
               cmdErr = `LSC_ERR_RANGE;
         end
         OP_TRIG_SET: begin
            if (!inRange(arg0, `LSC_PULSE_MIN_US, `LSC_PULSE_MAX_US))
               cmdErr = `LSC_ERR_RANGE;
         end
         default: cmdErr = `LSC_ERR_NONE;
      endcase
   end

   // =====================================================
   // argument and staging registers
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arg0 <= 16'h0000;
         arg1 <= 16'h0000;
      end else if (wrAcc && paddr == `LSC_REG_ARG0) begin
         arg0 <= pwdata[15:0];
      end else if (wrAcc && paddr == `LSC_REG_ARG1) begin
         arg1 <= pwdata[15:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (wrAcc && paddr == `LSC_REG_ARRAY && arrCnt < 5'(ARR_DEPTH))
         arrMem[arrCnt[3:0]] <= pwdata[15:0];
   end

   // =====================================================
   // list memories
   always_ff @(posedge core_clk) begin
      if (wrCmd && ok && (op == OP_SET_VOLT || op == OP_SET_CURR))
         setMem[ptrs.setCnt] <= arg0;
      else if (state == ST_COPY && arrIdx != arrCnt && validSet(arrMem[arrIdx[3:0]]) &&
               ptrs.setCnt < cap) begin
         setMem[ptrs.setCnt]   <= arrMem[arrIdx[3:0]];
         dwellMem[ptrs.setCnt] <= dwellMem[cpSrc];
      end else if (state == ST_FILL && fillLeft != 9'h0) begin
         setMem[ptrs.setCnt]   <= fillVal;
         dwellMem[ptrs.setCnt] <= sampDur;
      end
      if (wrCmd && ok && op == OP_DWELL)
         dwellMem[ptrs.dwellCnt] <= arg0;
   end

   // =====================================================
   // sequencer: pointers, copy and sample fill
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state    <= ST_IDLE;
         ptrs     <= '0;
         lastOp   <= OP_NONE;
         arrCnt   <= 5'h0;
         arrIdx   <= 5'h0;
         cpSrc    <= 13'h0;
         cpStart  <= 13'h0;
         cpEnd    <= 13'h0;
         fillLeft <= 9'h0;
         fillVal  <= 16'h0000;
         sampCnt  <= 4'h0;
         listCurr <= 1'b0;
         sampCurr <= 1'b0;
         qStart   <= 13'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wrAcc && paddr == `LSC_REG_ARRAY && arrCnt < 5'(ARR_DEPTH))
                  arrCnt <= arrCnt + 5'h1;
               if (wrCmd && ok) begin
                  lastOp <= op;
                  case (op)
                     OP_SET_VOLT, OP_SET_CURR: begin
                        ptrs.setCnt <= ptrs.setCnt + 13'h1;
                        listCurr    <= (op == OP_SET_CURR);
                     end
                     OP_DWELL: ptrs.dwellCnt <= ptrs.dwellCnt + 13'h1;
                     OP_COPY: begin
                        cpStart <= arg0[12:0];
                        cpEnd   <= arg1[12:0];
                        cpSrc   <= arg0[12:0];
                        arrIdx  <= 5'h0;
                        state   <= ST_COPY;
                     end
                     OP_SAMP_CURR, OP_SAMP_VOLT: begin
                        sampIdx[sampCnt[2:0]] <= ptrs.setCnt;
                        sampCnt  <= sampCnt + 4'h1;
                        sampCurr <= (op == OP_SAMP_CURR);
                        fillLeft <= avg;
                        fillVal  <= arg1;
                        state    <= ST_FILL;
                     end
                     OP_CLEAR: begin
                        ptrs    <= '0;
                        qStart  <= 13'h0;
                        sampCnt <= 4'h0;
                        arrCnt  <= 5'h0;
                     end
                     OP_QSTART_SET: qStart <= arg0[12:0];
                     default: lastOp <= op;
                  endcase
               end
            end
            ST_COPY: begin
               if (arrIdx == arrCnt || !validSet(arrMem[arrIdx[3:0]]) ||
                   ptrs.setCnt >= cap) begin
                  arrCnt <= 5'h0;
                  state  <= ST_IDLE;
               end else begin
                  ptrs.setCnt   <= ptrs.setCnt + 13'h1;
                  ptrs.dwellCnt <= ptrs.dwellCnt + 13'h1;
                  arrIdx        <= arrIdx + 5'h1;
                  cpSrc         <= (cpSrc == cpEnd) ? cpStart : cpSrc + 13'h1;
               end
            end
            ST_FILL: begin
               if (fillLeft == 9'h0) begin
                  state <= ST_IDLE;
               end else begin
                  ptrs.setCnt   <= ptrs.setCnt + 13'h1;
                  ptrs.dwellCnt <= ptrs.dwellCnt + 13'h1;
                  fillLeft      <= fillLeft - 9'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // =====================================================
   // pulse settings
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         durSet    <= 1'b0;
         sampDur   <= 16'h0000;
         trigMode  <= 1'b0;
         trigPolOn <= 1'b0;
         trigWidth <= 16'h0000;
      end else if (wrCmd && ok) begin
         if (op == OP_SAMP_DUR) begin
            durSet  <= 1'b1;
            sampDur <= arg0;
         end else if (op == OP_TRIG_SET) begin
            trigMode  <= 1'b1;
            trigWidth <= arg0;
            trigPolOn <= arg1[0];
         end else if (op == OP_CLEAR) begin
            trigMode <= 1'b0;
            durSet   <= 1'b0;
         end
      end
   end

   // flag transistor: trigger timing while armed, else output-off state
   always_ff @(posedge core_clk) begin
      if (!nrst)
         extFlagConduct <= 1'b0;
      else if (trigMode)
         extFlagConduct <= trigPolOn ? trigPulseActive : !trigPulseActive;
      else
         extFlagConduct <= outputOffState;
   end

   // =====================================================
   // error queue; a full queue drops the newest code
   logic       durRdErr;
   logic       pushErr;
   logic       popErr;
   logic [8:0] pushCode;

   assign durRdErr = rdAcc && paddr == `LSC_REG_SAMPDUR && !durSet;
   assign pushErr  = (wrCmd && !ok) || durRdErr;
   assign pushCode = durRdErr ? `LSC_ERR_COMMAND : cmdErr;
   assign popErr   = rdAcc && paddr == `LSC_REG_ERRQ && eqCnt != 3'h0;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         eqWr  <= 3'h0;
         eqRd  <= 3'h0;
         eqCnt <= 3'h0;
      end else begin
         if (pushErr && (eqCnt < 3'(EQ_DEPTH) || popErr)) begin
            eqMem[eqWr[1:0]] <= pushCode;
            eqWr <= eqWr + 3'h1;
         end
         if (popErr)
            eqRd <= eqRd + 3'h1;
         if (pushErr && eqCnt < 3'(EQ_DEPTH) && !popErr)
            eqCnt <= eqCnt + 3'h1;
         else if (popErr && !pushErr)
            eqCnt <= eqCnt - 3'h1;
      end
   end

   // =====================================================
   // read data, captured in the setup cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `LSC_REG_CMD:      prdata <= {28'h0, lastOp};
            `LSC_REG_ARG0:     prdata <= {16'h0, arg0};
            `LSC_REG_ARG1:     prdata <= {16'h0, arg1};
            `LSC_REG_ARRAY:    prdata <= {27'h0, arrCnt};
            `LSC_REG_STATUS:   prdata <= {26'h0, eqCnt != 3'h0, listCurr, trigPolOn,
                                          trigMode, durSet, busy};
            `LSC_REG_ERRQ:     prdata <= (eqCnt != 3'h0) ?
                                         {1'b1, 22'h0, eqMem[eqRd[1:0]]} : 32'h0;
            `LSC_REG_POINTS:   prdata <= {3'h0, ptrs.dwellCnt, 3'h0, ptrs.setCnt};
            `LSC_REG_QSTART:   prdata <= {19'h0, qStart};
            `LSC_REG_RES0:     prdata <= {16'h0, `LSC_DWELL_MIN_US};
            `LSC_REG_RES1:     prdata <= {16'h0, `LSC_DWELL_MAX_US};
            `LSC_REG_RES2:     prdata <= {19'h0, cap};
            `LSC_REG_SAMPINFO: prdata <= {16'h0, sampCurr ? `LSC_CHAR_C : `LSC_CHAR_V,
                                          4'h0, sampCnt};
            `LSC_REG_SAMPDUR:  prdata <= {16'h0, sampDur};
            `LSC_REG_TRIGCFG:  prdata <= {15'h0, trigPolOn, trigWidth};
            default: begin
               if (paddr[7:5] == 3'h2 && paddr[1:0] == 2'h0)
                  prdata <= {19'h0, sampIdx[paddr[4:2]]};
            end
         endcase
      end
   end
endmodule : lsc_command_checker
`default_nettype wire

// *** lsc_command_checker_assertions.sv ***
// Purpose: port checker for the list sequencer command checker
// Assumes: one clock, nrst synchronous and active low
// Notes:   only the APB side and the flag output are watched
`timescale 1ns/1ps
`default_nettype none
module lsc_command_checker_assertions (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        extFlagConduct
);
   // ==========
   // address map
   wire logic hole = (paddr[1:0] != 2'h0) || (paddr > 8'h34 && paddr < 8'h40) || (paddr > 8'h5C);
   wire logic acc  = psel && penable;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // ==========
   // properties
   a_reset_state: assert property ($rose(nrst) |-> prdata == 32'h0 && !extFlagConduct && pready)
      else $error("outputs not at reset values");
   a_hole_error: assert property (acc && hole |-> pslverr)
      else $error("unmapped access without slave error");
   a_hole_zero: assert property (acc && hole && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_mapped_ok: assert property (acc && !hole |-> !pslverr)
      else $error("slave error on mapped access");
   a_err_access: assert property (pslverr |-> acc)
      else $error("slave error outside access phase");
   a_read_nowait: assert property (!(psel && pwrite) |-> pready)
      else $error("ready low without a write");
   a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read setup");
   a_stall_bound: assert property (acc && pwrite && !pready |-> ##[1:1000] pready)
      else $error("write stalled too long");
   c_stall: cover property (acc && pwrite && !pready);
   c_hole: cover property (acc && hole);
   c_flag: cover property ($rose(extFlagConduct));
endmodule : lsc_command_checker_assertions

bind lsc_command_checker lsc_command_checker_assertions u_chk (
   .core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .extFlagConduct(extFlagConduct));
`default_nettype wire

// *** lsc_host_model.sv ***
// Purpose: APB master standing for the remote host
// Assumes: called right after a rising edge
// Notes:   one transfer at a time, idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
   input  wire logic        core_clk,
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   initial begin
      paddr <= 8'hFF;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      pwdata <= 32'h0;
   end
   // ==========
   // one transfer, strictly in issue order
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output bit ok);
      int n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (!pready && n < 2000);
      ok = pready;
      q = prdata;
      // released lines must not keep the old value
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge core_clk);
   endtask : xfer
endmodule : lsc_host_model
`default_nettype wire

// *** list_sequencer_command_checker_tb.sv ***
// Purpose: self-checking bench for the list sequencer command checker
// Assumes: command ops and register offsets of the shared header
// Notes:   reads note their expectation in a queue, a monitor compares
`include "lsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module list_sequencer_command_checker_tb
   import lsc_pkg::*;
;
   localparam logic [31:0] FULL = 32'hFFFF_FFFF;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  paddr;
   logic        psel, penable, pwrite, pready, pslverr, extFlagConduct;
   logic        resMax = 1'b0, trigPulseActive = 1'b0, outputOffState = 1'b0;
   logic [31:0] pwdata, prdata, lastRd;
   logic [31:0] expQ[$], mskQ[$];
   logic [15:0] rnd = 16'h001C;
   logic [12:0] setN;
   logic [15:0] avgTab[9] = '{16'h5, 16'h2, 16'h3, 16'h8, 16'h1F, 16'h21, 16'hFF, 16'h3E8, 16'h2};
   int          errorCnt = 0, checksDone = 0;
   always #2 core_clk = ~core_clk;
   lsc_command_checker dut (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .resMax(resMax), .trigPulseActive(trigPulseActive),
      .outputOffState(outputOffState), .extFlagConduct(extFlagConduct));
   lsc_host_model host (.core_clk(core_clk), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   // ==========
   // helpers
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsrNext
   function automatic int avgOf(input int r);
      int p = 2;
      while (p * 2 <= r && p < 256)
         p = p * 2;
      return p;
   endfunction : avgOf
   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tallyAndFinish
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      bit ok;
      host.xfer(a, w, d, lastRd, ok);
      if (!ok) begin
         errorCnt++;
         tallyAndFinish();
      end
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      expQ.push_back(e);
      mskQ.push_back(m);
      bus(a, 1'b0, 32'h0);
   endtask : rd
   task automatic cmd(input lsc_op_t op, input logic [15:0] a0, input logic [15:0] a1);
      bus(`LSC_REG_ARG0, 1'b1, {16'h0, a0});
      bus(`LSC_REG_ARG1, 1'b1, {16'h0, a1});
      bus(`LSC_REG_CMD, 1'b1, {28'h0, op});
   endtask : cmd
   task automatic err(input logic [8:0] c);
      rd(`LSC_REG_ERRQ, {1'b1, 22'h0, c}, 32'h8000_01FF);
   endtask : err
   task automatic pts(input logic [12:0] s, input logic [12:0] d);
      rd(`LSC_REG_POINTS, {3'h0, d, 3'h0, s}, 32'h1FFF_1FFF);
   endtask : pts
   // reads do not stall, so list counts are read only once busy drops
   task automatic idle();
      int n = 0;
      do begin
         rd(`LSC_REG_STATUS, 32'h0, 32'h0);
         n++;
      end while (lastRd[0] && n < 500);
      if (lastRd[0]) begin
         errorCnt++;
         tallyAndFinish();
      end
   endtask : idle
   task automatic flag(input logic t, input logic o, input logic e);
      trigPulseActive <= t;
      outputOffState <= o;
      repeat (2) @(posedge core_clk);
      chk("flag", {31'h0, e}, {31'h0, extFlagConduct});
   endtask : flag
   // ==========
   // monitor
   always @(posedge core_clk) begin : mon
      logic [31:0] e, m;
      if (psel && penable && pready && !pwrite && expQ.size() != 0) begin
         e = expQ.pop_front();
         m = mskQ.pop_front();
         if (m != 32'h0)
            chk($sformatf("reg %h", paddr), e & m, prdata & m);
      end
   end
   // ==========
   // scenarios
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(`LSC_REG_RES0, 32'h0000_005D, FULL);
      rd(`LSC_REG_RES1, 32'h0000_84D0, FULL);
      rd(`LSC_REG_RES2, 32'h0000_0F5D, FULL);
      resMax <= 1'b1;
      rd(`LSC_REG_RES2, 32'h0000_170C, FULL);
      rd(8'h38, 32'h0, FULL);
      $display("test resolution done");
      rd(`LSC_REG_SAMPDUR, 32'h0, 32'h0);
      err(9'h064);
      cmd(OP_SAMP_VOLT, 16'h0002, 16'h0);
      err(9'h0DD);
      rd(`LSC_REG_ERRQ, 32'h0, 32'h8000_0000);
      cmd(OP_QSTART_SET, 16'h0007, 16'h0);
      rd(`LSC_REG_QSTART, 32'h7, 32'h1FFF);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsrNext(rnd);
         cmd(OP_DWELL, i[0] ? 16'h84D0 : 16'h005D, 16'h0);
         cmd(OP_SET_VOLT, {4'h0, rnd[11:0]}, 16'h0);
      end
      cmd(OP_DWELL, 16'h005C, 16'h0);
      err(9'h0DE);
      cmd(OP_DWELL, 16'h84D1, 16'h0);
      err(9'h0DE);
      pts(3, 3);
      $display("test entry done");
      rnd = lfsrNext(rnd);
      bus(`LSC_REG_ARRAY, 1'b1, {20'h0, rnd[11:0]});
      bus(`LSC_REG_ARRAY, 1'b1, 32'h0000_7FFF);
      bus(`LSC_REG_ARRAY, 1'b1, 32'h0000_0001);
      cmd(OP_COPY, 16'h0000, 16'h0001);
      idle();
      pts(4, 4);
      cmd(OP_SET_VOLT, 16'h0010, 16'h0);
      cmd(OP_COPY, 16'h0003, 16'h0009);
      err(9'h0DD);
      cmd(OP_COPY, 16'h0000, 16'h0001);
      err(9'h0E2);
      pts(5, 4);
      cmd(OP_DWELL, 16'h0064, 16'h0);
      $display("test copy done");
      cmd(OP_SAMP_DUR, 16'h00F9, 16'h0);
      err(9'h0DE);
      cmd(OP_SAMP_DUR, 16'h00FA, 16'h0);
      cmd(OP_SAMP_DUR, 16'h0100, 16'h0);
      err(9'h064);
      rd(`LSC_REG_SAMPDUR, 32'h0000_00FA, FULL);
      setN = 13'h5;
      for (int i = 0; i < 9; i++) begin
         if (i > 0) begin
            cmd(OP_DWELL, 16'h0064, 16'h0);
            cmd(OP_SET_VOLT, 16'h0020, 16'h0);
            setN++;
         end
         cmd(i == 8 ? OP_SAMP_CURR : OP_SAMP_VOLT, avgTab[i], 16'h0030);
         if (i == 8) begin
            err(9'h0DF);
         end else begin
            idle();
            rd(`LSC_REG_SAMP0 | {3'h0, i[2:0], 2'h0}, {19'h0, setN}, 32'h1FFF);
            setN = setN + 13'(avgOf(int'(avgTab[i])));
         end
         pts(setN, setN);
      end
      rd(`LSC_REG_SAMPINFO, 32'h0000_5608, 32'h0000_FF0F);
      $display("test sampling done");
      flag(1'b0, 1'b1, 1'b1);
      cmd(OP_TRIG_SET, 16'h00FA, 16'h0001);
      flag(1'b1, 1'b0, 1'b1);
      flag(1'b0, 1'b1, 1'b0);
      cmd(OP_TRIG_SET, 16'h00FA, 16'h0000);
      flag(1'b1, 1'b1, 1'b0);
      cmd(OP_CLEAR, 16'h0, 16'h0);
      idle();
      pts(0, 0);
      rd(`LSC_REG_QSTART, 32'h0, 32'h1FFF);
      flag(1'b1, 1'b1, 1'b1);
      $display("test trigger and clear done");
      tallyAndFinish();
   end
endmodule : list_sequencer_command_checker_tb
`default_nettype wire
